// ==== logic/ddlr_top.v ====
// dll-off to dll-on relock controller with frequency change in self refresh
// assumes a classic wishbone master on i_clk and an idle, initialised ddr3 memory
`timescale 1ns/1ps
`default_nettype none
`include "ddlr_defines.vh"
module ddlr_top
(
   input  wire        i_clk,
   input  wire        i_rst_n,
   input  wire        i_wb_cyc,
   input  wire        i_wb_stb,
   input  wire        i_wb_we,
   input  wire [7:0]  i_wb_adr,
   input  wire [3:0]  i_wb_sel,
   input  wire [31:0] i_wb_dat,
   output reg         o_wb_ack,
   output reg  [31:0] o_wb_dat,
   output wire        o_ck,
   output reg         o_cke,
   output reg         o_odt,
   output reg         o_cs_n,
   output reg         o_ras_n,
   output reg         o_cas_n,
   output reg         o_we_n,
   output reg  [2:0]  o_ba,
   output reg  [15:0] o_addr
);

   // states name the next command to issue once the wait counter expires
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_PRE  = 4'h1;
   localparam [3:0] ST_SRE  = 4'h2;
   localparam [3:0] ST_FREQ = 4'h3;
   localparam [3:0] ST_SRX  = 4'h4;
   localparam [3:0] ST_MR1  = 4'h5;
   localparam [3:0] ST_MR0  = 4'h6;
   localparam [3:0] ST_MR2  = 4'h7;
   localparam [3:0] ST_ZQ   = 4'h8;
   localparam [3:0] ST_LOCK = 4'h9;

   // round a nanosecond figure up to whole cycles of the new clock
   function [15:0] ddlr_ru;
      input integer ns;
      input integer tck_ps;
      integer q;
      begin
         q = (ns * 1000 + tck_ps - 1) / tck_ps;
         ddlr_ru = q[15:0];
      end
   endfunction

   localparam integer TCK_NEW_PS = 2 * `DDLR_HALF_NEW * `DDLR_CLK_PS;
   localparam [15:0] TXS_RST = ddlr_ru(`DDLR_TXS_NS, TCK_NEW_PS);

   // software registers
   reg        odten_reg;
   reg        odtval_reg;
   reg        zqen_reg;
   reg        start_reg;
   reg        done_reg;
   reg [7:0]  half_old_reg;
   reg [7:0]  half_new_reg;
   reg [15:0] mr0_reg;
   reg [15:0] mr1_reg;
   reg [15:0] mr2_reg;
   reg [7:0]  tmrd_reg;
   reg [7:0]  tmod_reg;
   reg [15:0] txs_reg;
   reg [15:0] tdllk_reg;
   reg [15:0] tzq_reg;
   reg [7:0]  tcksre_reg;
   reg [7:0]  tcksrx_reg;
   reg [7:0]  trp_reg;

   // sequence state
   reg [3:0]  st_reg;
   reg [15:0] cnt_reg;
   reg [15:0] dllk_reg;
   reg [15:0] zq_reg;
   reg        sel_new_reg;
   reg        relock_reg;

   wire       fall_tick;
   wire       wb_req;
   wire       wb_wr;
   wire       busy;

   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wb_wr  = wb_req & i_wb_we;
   assign busy   = (st_reg != ST_IDLE);

   // clock toward the memory; commands change one i_clk cycle after its falling edge
   ddlr_ckgen u_ckgen
   (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_half_old  (half_old_reg),
      .i_half_new  (half_new_reg),
      .i_sel_new   (sel_new_reg),
      .o_ck        (o_ck),
      .o_fall_tick (fall_tick)
   );

   // ack one cycle after the request, dropped the cycle after
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end
      else
      begin
         o_wb_ack <= wb_req;
         o_wb_dat <= 32'h0000_0000;
         if (wb_req && !i_wb_we)
         begin
            case (i_wb_adr)
               `DDLR_OFS_CTRL:   o_wb_dat <= {28'h000_0000, zqen_reg, odtval_reg, odten_reg, 1'b0};
               `DDLR_OFS_STATUS: o_wb_dat <= {24'h00_0000, st_reg, 2'b00, done_reg, busy};
               `DDLR_OFS_HALF:   o_wb_dat <= {16'h0000, half_new_reg, half_old_reg};
               `DDLR_OFS_MR0:    o_wb_dat <= {16'h0000, mr0_reg};
               `DDLR_OFS_MR1:    o_wb_dat <= {16'h0000, mr1_reg};
               `DDLR_OFS_MR2:    o_wb_dat <= {16'h0000, mr2_reg};
               `DDLR_OFS_TMRS:   o_wb_dat <= {16'h0000, tmod_reg, tmrd_reg};
               `DDLR_OFS_TXS:    o_wb_dat <= {16'h0000, txs_reg};
               `DDLR_OFS_TDLLK:  o_wb_dat <= {16'h0000, tdllk_reg};
               `DDLR_OFS_TZQ:    o_wb_dat <= {16'h0000, tzq_reg};
               `DDLR_OFS_TSR:    o_wb_dat <= {8'h00, trp_reg, tcksrx_reg, tcksre_reg};
               default:          o_wb_dat <= 32'h0000_0000;
            endcase
         end
      end
   end

   // register writes; configuration is frozen while the sequence runs
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         odten_reg    <= 1'b1;
         odtval_reg   <= 1'b0;
         zqen_reg     <= 1'b0;
         half_old_reg <= `DDLR_HALF_OLD;
         half_new_reg <= `DDLR_HALF_NEW;
         mr0_reg      <= `DDLR_MR0_RST;
         mr1_reg      <= `DDLR_MR1_RST;
         mr2_reg      <= `DDLR_MR2_RST;
         tmrd_reg     <= `DDLR_TMRD_NCK;
         tmod_reg     <= `DDLR_TMOD_NCK;
         txs_reg      <= TXS_RST;
         tdllk_reg    <= `DDLR_TDLLK_NCK;
         tzq_reg      <= `DDLR_TZQ_NCK;
         tcksre_reg   <= `DDLR_TCKSRE_NCK;
         tcksrx_reg   <= `DDLR_TCKSRX_NCK;
         trp_reg      <= `DDLR_TRP_NCK;
      end
      else if (wb_wr && !busy && i_wb_sel[0])
      begin
         case (i_wb_adr)
            `DDLR_OFS_CTRL:
            begin
               odten_reg  <= i_wb_dat[`DDLR_CTRL_ODTEN];
               odtval_reg <= i_wb_dat[`DDLR_CTRL_ODTVAL];
               zqen_reg   <= i_wb_dat[`DDLR_CTRL_ZQEN];
            end
            `DDLR_OFS_HALF:
            begin
               half_old_reg <= i_wb_dat[7:0];
               half_new_reg <= i_wb_dat[15:8];
            end
            `DDLR_OFS_MR0:   mr0_reg   <= i_wb_dat[15:0];
            `DDLR_OFS_MR1:   mr1_reg   <= i_wb_dat[15:0];
            `DDLR_OFS_MR2:   mr2_reg   <= i_wb_dat[15:0];
            `DDLR_OFS_TMRS:
            begin
               tmrd_reg <= i_wb_dat[7:0];
               tmod_reg <= i_wb_dat[15:8];
            end
            `DDLR_OFS_TXS:   txs_reg   <= i_wb_dat[15:0];
            `DDLR_OFS_TDLLK: tdllk_reg <= i_wb_dat[15:0];
            `DDLR_OFS_TZQ:   tzq_reg   <= i_wb_dat[15:0];
            `DDLR_OFS_TSR:
            begin
               tcksre_reg <= i_wb_dat[7:0];
               tcksrx_reg <= i_wb_dat[15:8];
               trp_reg    <= i_wb_dat[23:16];
            end
            default:
            begin
               odten_reg <= odten_reg;
            end
         endcase
      end
   end

   // start request is held until the fsm takes it; a start while busy is dropped
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         start_reg <= 1'b0;
      end
      else if (wb_wr && !busy && i_wb_sel[0] && i_wb_adr == `DDLR_OFS_CTRL &&
               i_wb_dat[`DDLR_CTRL_START])
      begin
         start_reg <= 1'b1;
      end
      else if (busy)
      begin
         start_reg <= 1'b0;
      end
   end

   // sequencer: one decision per memory clock, taken one i_clk cycle after ck falls so the
   // command pins are settled half a period less one i_clk cycle before the rising edge samples them
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_reg      <= ST_IDLE;
         cnt_reg     <= 16'h0000;
         dllk_reg    <= 16'h0000;
         zq_reg      <= 16'h0000;
         sel_new_reg <= 1'b0;
         relock_reg  <= 1'b0;
         done_reg    <= 1'b0;
         o_cke       <= 1'b1;
         o_odt       <= 1'b0;
         o_cs_n      <= 1'b1;
         o_ras_n     <= 1'b1;
         o_cas_n     <= 1'b1;
         o_we_n      <= 1'b1;
         o_ba        <= 3'b000;
         o_addr      <= 16'h0000;
      end
      else if (fall_tick)
      begin
         // default no-operation on every wait cycle
         o_cs_n  <= busy ? 1'b0 : 1'b1;
         o_ras_n <= 1'b1;
         o_cas_n <= 1'b1;
         o_we_n  <= 1'b1;
         o_ba    <= 3'b000;
         o_addr  <= 16'h0000;
         // every counter steps once per memory clock edge
         if (cnt_reg != 16'h0000)
            cnt_reg <= cnt_reg - 16'h0001;
         if (dllk_reg != 16'h0000)
            dllk_reg <= dllk_reg - 16'h0001;
         if (zq_reg != 16'h0000)
            zq_reg <= zq_reg - 16'h0001;
         // odt is released only in the relock window and only without termination
         o_odt <= relock_reg & ~odten_reg & odtval_reg;
         case (st_reg)
            ST_IDLE:
            begin
               if (start_reg)
               begin
                  done_reg <= 1'b0;
                  st_reg   <= ST_PRE;
               end
            end
            ST_PRE:
            begin
               // precharge all so the memory is idle before self refresh
               o_ras_n <= 1'b0;
               o_we_n  <= 1'b0;
               o_addr  <= 16'h0400;
               cnt_reg <= {8'h00, trp_reg} - 16'h0001;
               st_reg  <= ST_SRE;
            end
            ST_SRE:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  o_ras_n <= 1'b0;
                  o_cas_n <= 1'b0;
                  o_cke   <= 1'b0;
                  cnt_reg <= {8'h00, tcksre_reg} - 16'h0001;
                  st_reg  <= ST_FREQ;
               end
            end
            ST_FREQ:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  sel_new_reg <= 1'b1;
                  cnt_reg     <= {8'h00, tcksrx_reg} - 16'h0001;
                  st_reg      <= ST_SRX;
               end
            end
            ST_SRX:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  o_cke      <= 1'b1;
                  relock_reg <= 1'b1;
                  cnt_reg    <= txs_reg - 16'h0001;
                  st_reg     <= ST_MR1;
               end
            end
            ST_MR1:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  // dll on: a0 forced low whatever software stored
                  o_ras_n <= 1'b0;
                  o_cas_n <= 1'b0;
                  o_we_n  <= 1'b0;
                  o_ba    <= 3'b001;
                  o_addr  <= mr1_reg & ~(16'h0001 << `DDLR_MR1_DLL_OFF);
                  cnt_reg <= {8'h00, tmrd_reg} - 16'h0001;
                  st_reg  <= ST_MR0;
               end
            end
            ST_MR0:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  // new latency and recovery go out together with the dll reset
                  o_ras_n  <= 1'b0;
                  o_cas_n  <= 1'b0;
                  o_we_n   <= 1'b0;
                  o_ba     <= 3'b000;
                  o_addr   <= mr0_reg | (16'h0001 << `DDLR_MR0_DLL_RST);
                  dllk_reg <= tdllk_reg - 16'h0001;
                  cnt_reg  <= {8'h00, tmrd_reg} - 16'h0001;
                  st_reg   <= ST_MR2;
               end
            end
            ST_MR2:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  o_ras_n <= 1'b0;
                  o_cas_n <= 1'b0;
                  o_we_n  <= 1'b0;
                  o_ba    <= 3'b010;
                  o_addr  <= mr2_reg;
                  cnt_reg <= {8'h00, tmod_reg} - 16'h0001;
                  st_reg  <= zqen_reg ? ST_ZQ : ST_LOCK;
               end
            end
            ST_ZQ:
            begin
               if (cnt_reg == 16'h0000)
               begin
                  o_we_n  <= 1'b0;
                  o_addr  <= 16'h0400;
                  zq_reg  <= tzq_reg - 16'h0001;
                  st_reg  <= ST_LOCK;
               end
            end
            ST_LOCK:
            begin
               if (cnt_reg == 16'h0000 && dllk_reg == 16'h0000 && zq_reg == 16'h0000)
               begin
                  relock_reg  <= 1'b0;
                  sel_new_reg <= sel_new_reg;
                  done_reg    <= 1'b1;
                  o_cs_n      <= 1'b1;
                  st_reg      <= ST_IDLE;
               end
            end
            default:
            begin
               st_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // ddlr_top
`default_nettype wire

// ==== logic/ddlr_defines.vh ====
// constants for the dll-off to dll-on relock controller: offsets, fields, resets, timing counts
// assumes a 32-bit classic wishbone slave and a ddr3 memory that is idle and initialised
//
// Contract
// - start only from idle: precharge all banks, odt low, before entering self refresh.
// - enter self refresh, wait the entry clock hold before changing clock frequency.
// - after frequency change give stable clock for exit clock time before exiting.
// - cke stays high from self refresh exit until dll lock time after reset.
// - with termination enabled at entry, odt stays low until dll lock expires.
// - with termination disabled at entry, odt may be driven low or high.
// - after exit delay write mode register 1 with bit a0 cleared, enabling dll.
// - after mode spacing write mode register 0 with bit a8 set, resetting dll.
// - after further spacing rewrite mode registers with values for the new clock.
// - long zq calibration may follow once mode update delay from last write is met.
// - wait full dll lock time after dll reset before commands needing locked dll.
// - if long zq calibration was issued, also wait the full zq operation time.
// - cycle timings count real clock edges; spacing of four means four edges later.
// - nanosecond timings become cycles by dividing by clock period, rounding up.
`ifndef DDLR_DEFINES_VH
`define DDLR_DEFINES_VH

// wishbone byte offsets
`define DDLR_OFS_CTRL     8'h00
`define DDLR_OFS_STATUS   8'h04
`define DDLR_OFS_HALF     8'h08
`define DDLR_OFS_MR0      8'h0C
`define DDLR_OFS_MR1      8'h10
`define DDLR_OFS_MR2      8'h14
`define DDLR_OFS_TMRS     8'h18
`define DDLR_OFS_TXS      8'h1C
`define DDLR_OFS_TDLLK    8'h20
`define DDLR_OFS_TZQ      8'h24
`define DDLR_OFS_TSR      8'h28

// control fields
`define DDLR_CTRL_START   0
`define DDLR_CTRL_ODTEN   1
`define DDLR_CTRL_ODTVAL  2
`define DDLR_CTRL_ZQEN    3

// mode register bits driven by the sequence
`define DDLR_MR1_DLL_OFF  0
`define DDLR_MR0_DLL_RST  8

// reset values (half periods in i_clk cycles, counts in memory clock cycles)
`define DDLR_HALF_OLD     8'h08
`define DDLR_HALF_NEW     8'h02
`define DDLR_MR0_RST      16'h0000
`define DDLR_MR1_RST      16'h0001
`define DDLR_MR2_RST      16'h0000
`define DDLR_TMRD_NCK     8'h04
`define DDLR_TMOD_NCK     8'h0C
`define DDLR_TRP_NCK      8'h04
`define DDLR_TCKSRE_NCK   8'h05
`define DDLR_TCKSRX_NCK   8'h05
`define DDLR_TDLLK_NCK    16'h0200
`define DDLR_TZQ_NCK      16'h0200

// nanosecond timing converted at elaboration and the i_clk period the new memory clock is built from
`define DDLR_TXS_NS       170
`define DDLR_CLK_PS       5000

`endif

// ==== logic/ddlr_ckgen.v ====
// memory clock generator: divides i_clk by a selectable half period
// assumes the half period values are at least one and only switch while cke is low
`timescale 1ns/1ps
`default_nettype none
module ddlr_ckgen
(
   input  wire       i_clk,
   input  wire       i_rst_n,
   input  wire [7:0] i_half_old,
   input  wire [7:0] i_half_new,
   input  wire       i_sel_new,
   output reg        o_ck,
   output reg        o_fall_tick
);

   reg [7:0] cnt_reg;
   wire [7:0] half_sel;

   // the new ratio is picked up only at a half-period boundary, so no runt pulse
   assign half_sel = i_sel_new ? i_half_new : i_half_old;

   // half-period counter; fall tick marks the cycle in which ck goes low
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_reg     <= 8'h00;
         o_ck        <= 1'b0;
         o_fall_tick <= 1'b0;
      end
      else
      begin
         o_fall_tick <= 1'b0;
         if (cnt_reg <= 8'h01)
         begin
            cnt_reg     <= half_sel;
            o_ck        <= ~o_ck;
            o_fall_tick <= o_ck;   // high going low
         end
         else
         begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end

endmodule // ddlr_ckgen
`default_nettype wire

// ==== dv/ddlr_top_chk.sv ====
// checker for the relock controller: wishbone answer and memory command pins
// assumes it is bound to ddlr_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ddlr_top_chk
(
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_ck,
   input wire logic        o_cke,
   input wire logic        o_odt,
   input wire logic        o_cs_n,
   input wire logic        o_ras_n,
   input wire logic        o_cas_n,
   input wire logic        o_we_n,
   input wire logic [2:0]  o_ba,
   input wire logic [15:0] o_addr
);
   // one clock domain, so clock and disable are declared once
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire [3:0] cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};

   property p_ack_resp; (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
   property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_dat_idle; !o_wb_ack |-> o_wb_dat == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   // pins move only while ck is low, so the memory edge never sees them mid-change
   property p_cmd_ck_low; $changed(cmd) |-> !o_ck; endproperty
   a_cmd_ck_low: assert property (p_cmd_ck_low) else $error("command changed with ck high");
   property p_cmd_hold; $changed(cmd) |=> $stable(cmd) [*3]; endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command held too short");
   property p_sre_ref; $fell(o_cke) |-> cmd == 4'h1; endproperty
   a_sre_ref: assert property (p_sre_ref) else $error("cke fell without refresh");
   property p_srx_nop; $rose(o_cke) |-> cmd == 4'h7; endproperty
   a_srx_nop: assert property (p_srx_nop) else $error("self refresh exit not a nop");
   property p_odt_sr; !o_cke |-> !o_odt; endproperty
   a_odt_sr: assert property (p_odt_sr) else $error("odt high in self refresh");
   property p_mr1_a0; (cmd == 4'h0 && o_ba == 3'h1) |-> !o_addr[0]; endproperty
   a_mr1_a0: assert property (p_mr1_a0) else $error("mode 1 write keeps dll off");
   property p_mr0_a8; (cmd == 4'h0 && o_ba == 3'h0) |-> o_addr[8]; endproperty
   a_mr0_a8: assert property (p_mr0_a8) else $error("mode 0 write lacks dll reset");

   c_sre: cover property ($fell(o_cke));
   c_zq: cover property (cmd == 4'h6);
   c_odt: cover property ($rose(o_odt));
endmodule // ddlr_top_chk
`default_nettype wire

// ==== dv/ddlr_mem_model.sv ====
// memory model: logs each selected non-nop command seen at a ck rise and tracks dll state
// assumes single-ended ck from the controller and active low command pins
`timescale 1ns/1ps
`default_nettype none
module ddlr_mem_model
(
   input wire logic        i_ck,
   input wire logic        i_cke,
   input wire logic        i_odt,
   input wire logic        i_cs_n,
   input wire logic        i_ras_n,
   input wire logic        i_cas_n,
   input wire logic        i_we_n,
   input wire logic [2:0]  i_ba,
   input wire logic [15:0] i_addr
);
   logic [3:0]  log_cmd [0:15];
   logic [2:0]  log_ba [0:15];
   logic [15:0] log_addr [0:15];
   int          log_edge [0:15];
   int          n_log = 0;
   int          edge_cnt = 0;
   int          srx_edge = 0;
   int          rel_end = 0;
   int          cke_drops = 0;
   int          odt_ones = 0;
   int          odt_zeros = 0;
   logic        cke_q = 1'b1;
   logic        relock = 1'b0;
   logic        dll_off = 1'b1;
   logic        dll_rst = 1'b0;
   wire  [3:0]  cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};

   // every ck rise is one counted edge; the log has room for a few runs only
   always @(posedge i_ck)
   begin
      edge_cnt <= edge_cnt + 1;
      cke_q <= i_cke;
      if (i_cke && !cke_q)
      begin
         srx_edge <= edge_cnt;
         relock <= 1'b1;
      end
      // relock window closes at the first deselect after exit
      if (relock)
      begin
         if (i_cs_n)
         begin
            relock <= 1'b0;
            rel_end <= edge_cnt;
         end
         if (!i_cke)
            cke_drops <= cke_drops + 1;
         if (i_odt)
            odt_ones <= odt_ones + 1;
         else
            odt_zeros <= odt_zeros + 1;
      end
      if (!i_cs_n && cmd != 4'h7 && n_log < 16)
      begin
         log_cmd[n_log] <= cmd;
         log_ba[n_log] <= i_ba;
         log_addr[n_log] <= i_addr;
         log_edge[n_log] <= edge_cnt;
         n_log <= n_log + 1;
      end
      if (cmd == 4'h0 && i_ba == 3'h1)
         dll_off <= i_addr[0];
      if (cmd == 4'h0 && i_ba == 3'h0)
         dll_rst <= i_addr[8];
   end
endmodule // ddlr_mem_model
`default_nettype wire

// ==== dv/ddlr_tb_top.sv ====
// testbench for the relock controller: wishbone master, memory model, sequence checks
// assumes the design's register map and timing defaults from its defines header
`timescale 1ns/1ps
`default_nettype none
`include "ddlr_defines.vh"
module ddlr_tb_top;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'hF;
   logic [31:0] wb_dat = 32'h0000_0000;
   wire         ack, ck, cke, odt, cs_n, ras_n, cas_n, we_n;
   wire  [31:0] rdat;
   wire  [2:0]  ba;
   wire  [15:0] addr;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc_cnt = 0;
   logic [7:0]  row_adr [0:11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                    8'h20, 8'h24, 8'h28, 8'h30};
   logic [31:0] row_exp [0:11] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0208, 32'h0000_0000,
                                    32'h0000_0001, 32'h0000_0000, 32'h0000_0C04, 32'h0000_0009,
                                    32'h0000_0200, 32'h0000_0200, 32'h0004_0505, 32'h0000_0000};
   // expected command list: code, bank, address, edges after the previous one (after self refresh exit for the mode register 1 write)
   logic [3:0]  e_cmd [0:5] = '{4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h6};
   logic [2:0]  e_ba [0:5] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0};
   logic [15:0] e_addr [0:5] = '{16'h0400, 16'h0000, 16'h0044, 16'h0B10, 16'h0018, 16'h0400};
   int          e_gap [0:5] = '{0, 4, 9, 4, 4, 12};

   always #2.5 i_clk = ~i_clk;

   ddlr_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
      .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat),
      .o_wb_ack(ack), .o_wb_dat(rdat), .o_ck(ck), .o_cke(cke), .o_odt(odt), .o_cs_n(cs_n),
      .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
   ddlr_mem_model u_mem (.i_ck(ck), .i_cke(cke), .i_odt(odt), .i_cs_n(cs_n), .i_ras_n(ras_n),
      .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // classic cycle: request held until ack is sampled, released on that edge
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge i_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      wb_sel <= sel;
      @(posedge i_clk);
      while (ack !== 1'b1 && n < 50)
      begin
         @(posedge i_clk);
         n++;
      end
      rd = rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      check(n < 50, 1'b1);
   endtask

   task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb_cycle(1'b1, adr, dat, 4'hF, d);
   endtask

   // one relock run; the expected list holds the zq entry last, so a run without it is shorter
   task automatic run_seq(input logic [31:0] ctrl, input int n_exp, input logic odt_hi);
      int b, k, dr, o1, o0;
      logic [31:0] rd;
      b = u_mem.n_log;
      dr = u_mem.cke_drops;
      o1 = u_mem.odt_ones;
      o0 = u_mem.odt_zeros;
      wb_wr(`DDLR_OFS_CTRL, ctrl);
      // start is taken only at a ck fall, up to a slow period later, so poll for busy
      k = 0;
      while (rd[0] !== 1'b1 && k < 20)
      begin
         wb_cycle(1'b0, `DDLR_OFS_STATUS, 32'h0, 4'hF, rd);
         k++;
      end
      check(rd[1:0], 2'b01);
      // written while busy, so it must be refused and tXS keep its default
      wb_wr(`DDLR_OFS_TXS, 32'h0000_0003);
      k = 0;
      while (rd[1] !== 1'b1 && k < 3000)
      begin
         wb_cycle(1'b0, `DDLR_OFS_STATUS, 32'h0, 4'hF, rd);
         k++;
      end
      check(rd[1:0], 2'b10);
      check(u_mem.n_log - b, n_exp);
      for (k = 0; k < n_exp; k++)
      begin
         check(u_mem.log_cmd[b+k], e_cmd[k]);
         check(u_mem.log_addr[b+k], e_addr[k]);
         if (e_cmd[k] == 4'h0)
            check(u_mem.log_ba[b+k], e_ba[k]);
         if (k == 2)
            check(u_mem.log_edge[b+2] - u_mem.srx_edge, 9);
         else if (k > 0)
            check(u_mem.log_edge[b+k] - u_mem.log_edge[b+k-1], e_gap[k]);
      end
      check(u_mem.srx_edge - u_mem.log_edge[b+1], `DDLR_TCKSRE_NCK + `DDLR_TCKSRX_NCK);
      check(u_mem.rel_end - u_mem.log_edge[b+3] >= 40, 1'b1);
      if (n_exp == 6)
         check(u_mem.rel_end - u_mem.log_edge[b+5] >= 30, 1'b1);
      check(u_mem.cke_drops - dr, 0);
      check(odt_hi ? u_mem.odt_zeros - o0 : u_mem.odt_ones - o1, 0);
      check({u_mem.dll_off, u_mem.dll_rst}, 2'b01);
      wb_cycle(1'b0, `DDLR_OFS_TXS, 32'h0, 4'hF, rd);
      check(rd, 32'h0000_0009);
      $display("test relock run done");
   endtask

   // hang guard, far above the few hundred cycles each run needs
   always @(posedge i_clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 40000)
      begin
         err_count++;
         give_verdict();
      end
   end

   initial
   begin : main
      logic [31:0] rd;
      real         t0;
      int          i;
      repeat (12) @(posedge i_clk);
      check({ack, cke, odt, cs_n, ras_n, cas_n, we_n}, 7'h2F);
      i_rst_n <= 1'b1;
      $display("test reset done");
      for (i = 0; i < 12; i++)
      begin
         wb_cycle(1'b0, row_adr[i], 32'h0, 4'hF, rd);
         check(rd, row_exp[i]);
      end
      $display("test register defaults done");
      wb_wr(`DDLR_OFS_TDLLK, 32'h0000_0028);
      wb_wr(`DDLR_OFS_TZQ, 32'h0000_001E);
      wb_wr(`DDLR_OFS_MR0, 32'h0000_0A10);
      wb_wr(`DDLR_OFS_MR1, 32'h0000_0045);
      wb_wr(`DDLR_OFS_MR2, 32'h0000_0018);
      wb_cycle(1'b1, `DDLR_OFS_MR2, 32'h0000_0055, 4'hE, rd);
      wb_cycle(1'b0, `DDLR_OFS_MR2, 32'h0, 4'hF, rd);
      check(rd, 32'h0000_0018);
      run_seq(32'h0000_000D, 6, 1'b1);
      @(posedge ck);
      t0 = $realtime;
      @(posedge ck);
      check(32'($rtoi($realtime - t0)), 32'd20);
      run_seq(32'h0000_0007, 5, 1'b0);
      give_verdict();
   end
endmodule // ddlr_tb_top

bind ddlr_top ddlr_top_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_ck(o_ck),
   .o_cke(o_cke), .o_odt(o_odt), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
   .o_we_n(o_we_n), .o_ba(o_ba), .o_addr(o_addr));
`default_nettype wire
